// >>> hdl/rpt_timer.sv
// protocol timer: axi4-lite registers, prescaled 16-bit countdown and interrupt
// Behaviour
// - auto start bit set: end of transmission starts the timer.
// - auto start, single reception: first received data bit stops the timer.
// - auto start, many frames: timer stops only on software stop command or on expiry.
// - auto start clear: transmission and reception events are ignored.
// - gate field picks no gate, card signal pin or first auxiliary pin.
// - running flag shows enabled timer whatever the gate level.
// - auto reload set: counter reloads at zero and keeps counting.
// - auto reload clear: count to zero, then raise expired request.
// - prescale value is mode nibble above prescale low byte.
// - tick rate is carrier rate over prescale value plus one.
// - reload value held in two read/write bytes, reset zero.
// - every start copies reload value into the counter.
// - reload writes leave a running count alone until next start or auto reload at zero.
// - upper counter byte readable, read only.
// - lower counter byte readable, read only.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "rpt_map.svh"
module rpt_timer
  import rpt_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PRESCALE_W = 12,
  parameter int COUNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic carrier_strobe,
  input wire rpt_proto_t proto_event,
  input wire logic card_signal_input_pin,
  input wire logic first_auxiliary_pin,
  output logic irq
);

  if (ADDR_W < 8) begin
    $error("rpt_timer: ADDR_W must reach the register map");
  end
  if (PRESCALE_W != 12 || COUNT_W != 16) begin
    $error("rpt_timer: byte register layout needs 12/16 bit widths");
  end

  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[7:2];
  endfunction

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx == `RPT_IDX_MODE) || (idx == `RPT_IDX_PRESC_LO)
      || (idx == `RPT_IDX_RELOAD_HI) || (idx == `RPT_IDX_RELOAD_LO)
      || (idx == `RPT_IDX_COUNT_HI) || (idx == `RPT_IDX_COUNT_LO)
      || (idx == `RPT_IDX_CONTROL) || (idx == `RPT_IDX_IRQ_MASK)
      || (idx == `RPT_IDX_IRQ_STATUS) || (idx == `RPT_IDX_STATUS);
  endfunction

  // ---- write channel ----
  logic aw_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic w_held_ff;
  logic [7:0] w_data_ff;
  logic w_lane0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  wire logic aw_fire;
  wire logic w_fire;
  wire logic wr_do;
  wire logic [5:0] wr_idx;
  wire logic wr_hit;
  wire logic wr_en;

  // one write in flight: channels close until the response is taken
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_held_ff && w_held_ff;
  assign wr_idx = reg_index(aw_addr_ff);
  assign wr_hit = idx_mapped(wr_idx);
  // registers are one byte wide, only lane 0 carries data
  assign wr_en = wr_do && wr_hit && w_lane0_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff <= 1'b0;
      w_data_ff <= `RPT_RST_BYTE;
      w_lane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RPT_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_lane0_ff <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `RPT_RESP_OKAY : `RPT_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ---- write decode ----
  wire logic sel_mode;
  wire logic sel_presc;
  wire logic sel_rel_hi;
  wire logic sel_rel_lo;
  wire logic sel_ctrl;
  wire logic sel_mask;
  wire logic sw_stop;
  wire logic sw_start;

  assign sel_mode = wr_en && (wr_idx == `RPT_IDX_MODE);
  assign sel_presc = wr_en && (wr_idx == `RPT_IDX_PRESC_LO);
  assign sel_rel_hi = wr_en && (wr_idx == `RPT_IDX_RELOAD_HI);
  assign sel_rel_lo = wr_en && (wr_idx == `RPT_IDX_RELOAD_LO);
  assign sel_ctrl = wr_en && (wr_idx == `RPT_IDX_CONTROL);
  assign sel_mask = wr_en && (wr_idx == `RPT_IDX_IRQ_MASK);
  assign sw_stop = sel_ctrl && w_data_ff[`RPT_CTRL_STOP_BIT];
  assign sw_start = sel_ctrl && w_data_ff[`RPT_CTRL_START_BIT];

  // ---- configuration registers ----
  rpt_mode_t mode_ff;
  logic [7:0] presc_lo_ff;
  logic [7:0] reload_hi_ff;
  logic [7:0] reload_lo_ff;
  logic many_ff;
  logic [1:0] mask_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= rpt_mode_t'(`RPT_RST_BYTE);
      presc_lo_ff <= `RPT_RST_BYTE;
      reload_hi_ff <= `RPT_RST_BYTE;
      reload_lo_ff <= `RPT_RST_BYTE;
      many_ff <= 1'b0;
      mask_ff <= `RPT_RST_IRQ;
    end else begin
      if (sel_mode) mode_ff <= rpt_mode_t'(w_data_ff);
      if (sel_presc) presc_lo_ff <= w_data_ff;
      if (sel_rel_hi) reload_hi_ff <= w_data_ff;
      if (sel_rel_lo) reload_lo_ff <= w_data_ff;
      if (sel_ctrl) many_ff <= w_data_ff[`RPT_CTRL_MANY_BIT];
      if (sel_mask) mask_ff <= w_data_ff[1:0];
    end
  end

  // ---- prescaler ----
  wire logic [PRESCALE_W-1:0] prescale_value;
  wire logic tick;
  wire logic start_ev;

  assign prescale_value = {mode_ff.prescale_upper_nibble, presc_lo_ff};

  // restarting on every start keeps the first tick a full period away
  rpt_prescaler #(
    .PRESCALE_W(PRESCALE_W)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(start_ev),
    .carrier_strobe(carrier_strobe),
    .prescale_value(prescale_value),
    .tick(tick)
  );

  // ---- gating ----
  logic gate_open;

  always_comb begin
    unique case (mode_ff.gate_source_select)
      RPT_GATE_CARD: gate_open = card_signal_input_pin;
      RPT_GATE_AUX: gate_open = first_auxiliary_pin;
      RPT_GATE_NONE: gate_open = 1'b1;
      RPT_GATE_RSVD: gate_open = 1'b1;
    endcase
  end

  // ---- start, stop and countdown ----
  rpt_state_t state_ff;
  rpt_state_t nxt_state;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;

  wire logic running;
  wire logic auto_start;
  wire logic auto_stop;
  wire logic stop_ev;
  wire logic tick_ok;
  wire logic count_low;
  wire logic expire;
  wire logic wrap;
  wire logic [COUNT_W-1:0] reload_value;

  assign running = (state_ff == RPT_ST_RUN);
  assign reload_value = {reload_hi_ff, reload_lo_ff};
  // protocol events count only with auto start set
  assign auto_start = mode_ff.auto_start_on_tx_end && proto_event.tx_end;
  assign auto_stop = mode_ff.auto_start_on_tx_end && !many_ff
    && proto_event.rx_first_bit && running;
  assign start_ev = sw_start || auto_start;
  assign stop_ev = sw_stop || auto_stop;
  assign tick_ok = running && tick && gate_open;
  assign count_low = (count_ff <= COUNT_W'(1));
  assign expire = tick_ok && !mode_ff.auto_reload_enable && count_low;
  assign wrap = tick_ok && mode_ff.auto_reload_enable
    && (count_ff == '0);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RPT_ST_IDLE: begin
        if (start_ev && !stop_ev) begin
          nxt_state = RPT_ST_RUN;
        end
      end
      RPT_ST_RUN: begin
        // a stop in the same cycle as a start wins
        if (stop_ev || expire) begin
          nxt_state = RPT_ST_IDLE;
        end
      end
      default: nxt_state = RPT_ST_IDLE;
    endcase
  end

  always_comb begin
    nxt_count = count_ff;
    if (start_ev) begin
      nxt_count = reload_value;
    end else if (wrap) begin
      nxt_count = reload_value;
    end else if (tick_ok && (count_ff != '0)) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= RPT_ST_IDLE;
      count_ff <= `RPT_RST_COUNT;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  // ---- read channel ----
  logic rvalid_ff;
  logic [7:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rd_mux;

  wire logic ar_fire;
  wire logic [5:0] rd_idx;
  wire logic rd_hit;
  wire logic rd_clr_irq;

  assign s_axi_arready = !rvalid_ff;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = reg_index(s_axi_araddr);
  assign rd_hit = idx_mapped(rd_idx);
  assign rd_clr_irq = ar_fire && (rd_idx == `RPT_IDX_IRQ_STATUS);
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = {24'h000000, rdata_ff};
  assign s_axi_rresp = rresp_ff;

  // ---- interrupt status ----
  logic [1:0] irq_ff;
  logic [1:0] irq_set;
  logic [1:0] nxt_irq;

  always_comb begin
    irq_set = '0;
    irq_set[`RPT_IRQ_EXPIRED_BIT] = expire;
    irq_set[`RPT_IRQ_RELOAD_BIT] = wrap;
    // an event landing on the clearing read survives it
    nxt_irq = (rd_clr_irq ? 2'h0 : irq_ff) | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= `RPT_RST_IRQ;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq = |(irq_ff & mask_ff);

  always_comb begin
    rd_mux = 8'h00;
    unique case (rd_idx)
      `RPT_IDX_MODE: rd_mux = mode_ff;
      `RPT_IDX_PRESC_LO: rd_mux = presc_lo_ff;
      `RPT_IDX_RELOAD_HI: rd_mux = reload_hi_ff;
      `RPT_IDX_RELOAD_LO: rd_mux = reload_lo_ff;
      `RPT_IDX_COUNT_HI: rd_mux = count_ff[15:8];
      `RPT_IDX_COUNT_LO: rd_mux = count_ff[7:0];
      `RPT_IDX_CONTROL: rd_mux[`RPT_CTRL_MANY_BIT] = many_ff;
      `RPT_IDX_IRQ_MASK: rd_mux[1:0] = mask_ff;
      `RPT_IDX_IRQ_STATUS: rd_mux[1:0] = irq_ff;
      `RPT_IDX_STATUS: begin
        rd_mux[`RPT_STAT_RUN_BIT] = running;
        rd_mux[`RPT_STAT_GATE_BIT] = gate_open;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `RPT_RST_BYTE;
      rresp_ff <= `RPT_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? `RPT_RESP_OKAY : `RPT_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// >>> hdl/rpt_map.svh
// register indices, field positions, reset values and bus codes of the protocol timer
`ifndef RPT_MAP_SVH
`define RPT_MAP_SVH

// register indices; byte address is four times the index
`define RPT_IDX_MODE 6'h2A
`define RPT_IDX_PRESC_LO 6'h2B
`define RPT_IDX_RELOAD_HI 6'h2C
`define RPT_IDX_RELOAD_LO 6'h2D
`define RPT_IDX_COUNT_HI 6'h2E
`define RPT_IDX_COUNT_LO 6'h2F
`define RPT_IDX_CONTROL 6'h0C
`define RPT_IDX_IRQ_MASK 6'h02
`define RPT_IDX_IRQ_STATUS 6'h04
`define RPT_IDX_STATUS 6'h07

// control register bits
`define RPT_CTRL_STOP_BIT 7
`define RPT_CTRL_START_BIT 6
`define RPT_CTRL_MANY_BIT 0

// interrupt status / mask bits
`define RPT_IRQ_EXPIRED_BIT 0
`define RPT_IRQ_RELOAD_BIT 1

// status register bits
`define RPT_STAT_RUN_BIT 0
`define RPT_STAT_GATE_BIT 1

// reset values
`define RPT_RST_BYTE 8'h00
`define RPT_RST_IRQ 2'h0
`define RPT_RST_COUNT 16'h0000

// axi response codes
`define RPT_RESP_OKAY 2'h0
`define RPT_RESP_SLVERR 2'h2

`endif

// >>> hdl/rpt_pkg.sv
// types shared by the protocol timer files
package rpt_pkg;

  typedef enum logic [1:0] {
    RPT_GATE_NONE = 2'h0,
    RPT_GATE_CARD = 2'h1,
    RPT_GATE_AUX = 2'h2,
    RPT_GATE_RSVD = 2'h3
  } rpt_gate_t;

  typedef struct packed {
    logic auto_start_on_tx_end;
    rpt_gate_t gate_source_select;
    logic auto_reload_enable;
    logic [3:0] prescale_upper_nibble;
  } rpt_mode_t;

  typedef enum logic [1:0] {
    RPT_ST_IDLE = 2'b01,
    RPT_ST_RUN = 2'b10
  } rpt_state_t;

  typedef struct packed {
    logic tx_end;
    logic rx_first_bit;
  } rpt_proto_t;

endpackage

// >>> hdl/rpt_prescaler.sv
// divides the carrier strobe by prescale_value plus one into timer ticks
`timescale 1ns/100ps
`include "rpt_map.svh"
module rpt_prescaler
  import rpt_pkg::*;
#(
  parameter int PRESCALE_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic carrier_strobe,
  input wire logic [PRESCALE_W-1:0] prescale_value,
  output logic tick
);

  // widths the divider cannot serve are refused at elaboration
  if (PRESCALE_W < 1 || PRESCALE_W > 16) begin
    $error("rpt_prescaler: PRESCALE_W out of range");
  end

  logic [PRESCALE_W-1:0] div_ff;
  logic [PRESCALE_W-1:0] nxt_div;
  wire logic at_end;

  // >= so a lowered prescale value never strands the divider above it
  assign at_end = (div_ff >= prescale_value);
  assign tick = carrier_strobe && at_end;

  always_comb begin
    nxt_div = div_ff;
    if (restart) begin
      nxt_div = '0;
    end else if (carrier_strobe) begin
      nxt_div = at_end ? '0 : div_ff + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

endmodule

// >>> bench/rpt_timer_sva.sv
// bus handshake and response checks on the protocol timer ports
`timescale 1ns/100ps
`include "rpt_map.svh"
module rpt_timer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  rd_busy_a: assert property (s_axi_arready != s_axi_rvalid)
    else $error("read ready not inverse of rvalid");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  byte_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data beyond byte lane");
  b_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {`RPT_RESP_OKAY, `RPT_RESP_SLVERR})
    else $error("bad write response code");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  err_c: cover property (s_axi_rvalid && s_axi_rresp == `RPT_RESP_SLVERR);
  irq_c: cover property ($rose(irq));
endmodule

// >>> bench/tb_rpt_timer.sv
// self-checking bench for the protocol timer
`timescale 1ns/100ps
`include "rpt_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %0t: got %h exp %h", $time, (a), (e)); end end
module tb_rpt_timer import rpt_pkg::*;;
  logic aclk = 1'h0, aresetn = 1'h0, irq, carrier_strobe = 1'h0;
  logic card_signal_input_pin = 1'h0, first_auxiliary_pin = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  rpt_proto_t proto_event = 2'h0;
  int num_errors = 0, n_tests = 0;
  always #12.5 aclk = ~aclk;
  rpt_timer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .carrier_strobe, .proto_event, .card_signal_input_pin, .first_auxiliary_pin, .irq);
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // handshakes judged at the falling edge, acted on at the next rising edge;
  // read ready comes a cycle late on purpose so the slave must hold its read answer; write ready rises with the response
  task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d);
    int n;
    logic ha, hw, hb;
    n = 0;
    hb = 1'h0;
    @(posedge aclk);
    if (we) begin
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
    end else begin
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
    end
    while (!hb) begin
      @(negedge aclk);
      ha = we ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = we ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      q = s_axi_rdata;
      r = we ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ha && we) s_axi_awvalid <= 1'h0;
      if (ha && !we) s_axi_arvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      if (n == 2) s_axi_bready <= we;
      if (n == 2) s_axi_rready <= !we;
      if (hb) s_axi_bready <= 1'h0;
      if (hb) s_axi_rready <= 1'h0;
      if (n > 100) begin
        num_errors++;
        final_report();
      end
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'h1, i, d);
  endtask
  task automatic rd(input logic [5:0] i);
    bus(1'h0, i, 8'h00);
  endtask
  task automatic strobes(input int k);
    repeat (k) begin
      @(posedge aclk);
      carrier_strobe <= 1'h1;
      @(posedge aclk);
      carrier_strobe <= 1'h0;
    end
    @(negedge aclk);
  endtask
  task automatic pev(input rpt_proto_t e);
    @(posedge aclk);
    proto_event <= e;
    @(posedge aclk);
    proto_event <= 2'h0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic cnt(input logic [15:0] e);
    rd(`RPT_IDX_COUNT_HI);
    `CHK(q[7:0], e[15:8])
    rd(`RPT_IDX_COUNT_LO);
    `CHK(q[7:0], e[7:0])
  endtask
  task automatic run(input logic e);
    rd(`RPT_IDX_STATUS);
    `CHK(q[`RPT_STAT_RUN_BIT], e)
  endtask
  task automatic t_regs();
    for (int i = 'h2A; i <= 'h2D; i++) begin
      rd(6'(i));
      `CHK(q, 32'h00000000)
    end
    wr(`RPT_IDX_RELOAD_HI, 8'h5A);
    rd(`RPT_IDX_RELOAD_HI);
    `CHK(q, 32'h0000005A)
    wr(`RPT_IDX_COUNT_HI, 8'hFF);
    `CHK(r, `RPT_RESP_OKAY)
    cnt(16'h0000);
    rd(6'h3F);
    `CHK(r, `RPT_RESP_SLVERR)
    `CHK(q, 32'h00000000)
    wr(6'h3F, 8'h00);
    `CHK(r, `RPT_RESP_SLVERR)
  endtask
  task automatic t_presc();
    wr(`RPT_IDX_MODE, 8'h01);
    wr(`RPT_IDX_PRESC_LO, 8'h01);
    wr(`RPT_IDX_RELOAD_HI, 8'h03);
    wr(`RPT_IDX_RELOAD_LO, 8'h05);
    wr(`RPT_IDX_CONTROL, 8'h40);
    // prescale 0x101: one tick per 258 strobes, one strobe short of a third tick
    strobes(773);
    cnt(16'h0303);
    wr(`RPT_IDX_RELOAD_LO, 8'hAA);
    strobes(1);
    cnt(16'h0302);
    run(1'h1);
    wr(`RPT_IDX_CONTROL, 8'h40);
    cnt(16'h03AA);
    wr(`RPT_IDX_CONTROL, 8'h80);
  endtask
  task automatic t_expire();
    wr(`RPT_IDX_MODE, 8'h00);
    wr(`RPT_IDX_PRESC_LO, 8'h00);
    wr(`RPT_IDX_RELOAD_HI, 8'h00);
    wr(`RPT_IDX_RELOAD_LO, 8'h02);
    wr(`RPT_IDX_IRQ_MASK, 8'h01);
    wr(`RPT_IDX_CONTROL, 8'h40);
    strobes(1);
    `CHK(irq, 1'h0)
    strobes(1);
    `CHK(irq, 1'h1)
    run(1'h0);
    rd(`RPT_IDX_IRQ_STATUS);
    `CHK(q, 32'h00000001)
    @(negedge aclk);
    `CHK(irq, 1'h0)
    wr(`RPT_IDX_IRQ_MASK, 8'h00);
    wr(`RPT_IDX_CONTROL, 8'h40);
    strobes(2);
    `CHK(irq, 1'h0)
    rd(`RPT_IDX_IRQ_STATUS);
    `CHK(q, 32'h00000001)
  endtask
  task automatic t_reload();
    wr(`RPT_IDX_MODE, 8'h10);
    wr(`RPT_IDX_IRQ_MASK, 8'h02);
    wr(`RPT_IDX_CONTROL, 8'h40);
    strobes(3);
    `CHK(irq, 1'h1)
    cnt(16'h0002);
    rd(`RPT_IDX_IRQ_STATUS);
    `CHK(q, 32'h00000002)
    @(negedge aclk);
    `CHK(irq, 1'h0)
    run(1'h1);
    wr(`RPT_IDX_CONTROL, 8'h80);
  endtask
  task automatic t_auto();
    wr(`RPT_IDX_MODE, 8'h80);
    wr(`RPT_IDX_RELOAD_LO, 8'h05);
    pev(2'h2);
    strobes(2);
    cnt(16'h0003);
    pev(2'h1);
    run(1'h0);
    strobes(1);
    cnt(16'h0003);
    wr(`RPT_IDX_CONTROL, 8'h01);
    pev(2'h2);
    pev(2'h1);
    strobes(1);
    cnt(16'h0004);
    wr(`RPT_IDX_CONTROL, 8'h81);
    run(1'h0);
    wr(`RPT_IDX_CONTROL, 8'h00);
    wr(`RPT_IDX_MODE, 8'h00);
    pev(2'h2);
    run(1'h0);
    wr(`RPT_IDX_CONTROL, 8'h40);
    pev(2'h1);
    run(1'h1);
    wr(`RPT_IDX_CONTROL, 8'h80);
  endtask
  task automatic t_gate();
    // gate steps: closed, card pin open, auxiliary pin open
    logic [15:0] ex [4][3];
    ex = '{'{16'h3, 16'h2, 16'h1}, '{16'h4, 16'h3, 16'h3},
      '{16'h4, 16'h4, 16'h3}, '{16'h3, 16'h2, 16'h1}};
    wr(`RPT_IDX_RELOAD_LO, 8'h04);
    for (int g = 0; g < 4; g++) begin
      wr(`RPT_IDX_MODE, {1'h0, 2'(g), 5'h00});
      wr(`RPT_IDX_CONTROL, 8'h40);
      run(1'h1);
      for (int s = 0; s < 3; s++) begin
        @(posedge aclk);
        card_signal_input_pin <= (s == 1);
        first_auxiliary_pin <= (s == 2);
        strobes(1);
        cnt(ex[g][s]);
      end
      wr(`RPT_IDX_CONTROL, 8'h80);
    end
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_presc();
    t_expire();
    t_reload();
    t_auto();
    t_gate();
    final_report();
  end
endmodule
bind rpt_timer rpt_timer_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
